// ==== logic/sefe_pkg.sv ====
// package: constants and types for the serial eeprom slave front end
package sefe_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;       // pclk period at 40 MHz
	localparam int T_WRITE_NS    = 5000000;  // longest programming time, 5 ms
	// longest time rounds down to whole cycles
	localparam int WRITE_CYC     = T_WRITE_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// storage geometry
	// ----------------------------------------------------------------
	localparam int ARRAY_BYTES = 16384;      // main array, one byte per location
	localparam int PAGE_BYTES  = 64;         // page and id page size
	localparam int ADDR_W      = 14;         // byte address width of the array
	localparam int PAGE_W      = 6;          // offset width inside a page

	// ----------------------------------------------------------------
	// select code
	// ----------------------------------------------------------------
	localparam logic [3:0] TYPE_ARRAY  = 4'ha;   // 1010
	localparam logic [3:0] TYPE_IDPAGE = 4'hb;   // 1011
	localparam logic [3:0] BYTE_BITS   = 4'h8;   // bits per byte on the wire
	localparam logic [1:0] IDX_SEL     = 2'h0;   // select code byte
	localparam logic [1:0] IDX_ADDR_HI = 2'h1;   // most significant address byte
	localparam logic [1:0] IDX_ADDR_LO = 2'h2;   // least significant address byte
	localparam logic [1:0] IDX_DATA    = 2'h3;   // data bytes

	// ----------------------------------------------------------------
	// register map (byte addresses) and fields
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_STATUS    = 12'h000;
	localparam logic [11:0] OFF_CTRL      = 12'h004;
	localparam logic [11:0] OFF_PEEK_ADDR = 12'h008;
	localparam logic [11:0] OFF_PEEK_DATA = 12'h00c;
	localparam int STAT_STANDBY_BIT = 0;
	localparam int STAT_BUSY_BIT    = 1;
	localparam int STAT_WP_BIT      = 2;
	localparam int STAT_LOCK_BIT    = 3;
	localparam int CTRL_LOCK_BIT    = 0;
	localparam logic        LOCK_RST  = 1'b0;
	localparam logic [13:0] PEEK_RST  = 14'h0000;

	// ----------------------------------------------------------------
	// link state machine
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_STANDBY = 3'b000,  // idle, waiting for a start
		ST_RX      = 3'b001,  // shifting a byte in
		ST_ACK     = 3'b010,  // ninth clock, device answers
		ST_TX      = 3'b011,  // shifting a byte out
		ST_MACK    = 3'b100,  // ninth clock, master answers
		ST_WRITE   = 3'b101   // internal programming cycle
	} sefe_state_t;

endpackage

// ==== logic/sefe_top.sv ====
// serial eeprom slave front end: bus sampling, select match, acks, write cycle
`timescale 1ns/1ps
module sefe_top #(
	parameter int unsigned WRITE_CYCLES = sefe_pkg::WRITE_CYC,   // programming time in pclk
	parameter bit          HAS_ID_PAGE  = 1'b1                   // variant with the id page
) (
	input  wire logic        pclk,
	input  wire logic        presetn,              // from the power-on detector
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        scl,                  // serial clock, also the link clock
	input  wire logic        sda_i,                // data line level
	output logic             sda_o,                // always low when enabled
	output logic             sda_oe,               // high while pulling the line low
	input  wire logic        strap_select_bit2,
	input  wire logic        strap_select_bit1,
	input  wire logic        strap_select_bit0,
	input  wire logic        write_protect_input,
	output logic             standby
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (WRITE_CYCLES < 2) begin : g_bad_cycles
		$error("WRITE_CYCLES must be at least 2");
	end

	// ----------------------------------------------------------------
	// link domain: byte shifter on the serial clock
	// ----------------------------------------------------------------
	logic [7:0] link_shift_reg;    // last eight bits seen on rising scl
	logic [7:0] link_shift_next;

	// shift msb first on every rising scl edge
	always_comb begin
		link_shift_next = {link_shift_reg[6:0], sda_i};
	end

	// no reset value matters for a shifter, but give one anyway
	always_ff @(posedge scl or negedge presetn) begin
		if (!presetn) begin
			link_shift_reg <= 8'h00;
		end else begin
			link_shift_reg <= link_shift_next;
		end
	end

	// ----------------------------------------------------------------
	// synchronisers into pclk
	// ----------------------------------------------------------------
	logic       scl_m, scl_s, scl_d;   // meta, stable, delayed
	logic       sda_m, sda_s, sda_d;
	logic [2:0] strap_m, strap_s;
	logic       wp_m, wp_s;

	// two flops per pin, a third only for the edge detectors
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_m   <= 1'b1;
			scl_s   <= 1'b1;
			scl_d   <= 1'b1;
			sda_m   <= 1'b1;
			sda_s   <= 1'b1;
			sda_d   <= 1'b1;
			strap_m <= 3'h0;
			strap_s <= 3'h0;
			wp_m    <= 1'b0;
			wp_s    <= 1'b0;
		end else begin
			scl_m   <= scl;
			scl_s   <= scl_m;
			scl_d   <= scl_s;
			sda_m   <= sda_i;
			sda_s   <= sda_m;
			sda_d   <= sda_s;
			strap_m <= {strap_select_bit2, strap_select_bit1, strap_select_bit0};
			strap_s <= strap_m;
			wp_m    <= write_protect_input;
			wp_s    <= wp_m;
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise  = scl_s & ~scl_d;
	assign scl_fall  = ~scl_s & scl_d;
	// data edges while the clock stays high
	assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
	assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	localparam int AW = sefe_pkg::ADDR_W;
	localparam int PW = sefe_pkg::PAGE_W;
	localparam int NP = sefe_pkg::PAGE_BYTES;

	logic [7:0] mem_reg  [sefe_pkg::ARRAY_BYTES];  // main array
	logic [7:0] mem_next [sefe_pkg::ARRAY_BYTES];
	logic [7:0] id_reg   [NP];                     // identification page
	logic [7:0] id_next  [NP];
	logic [7:0] buf_reg  [NP];                     // page being collected
	logic [7:0] buf_next [NP];
	logic       lock_reg, lock_next;               // id page locked until the next reset

	// read one byte from the array or from the id page
	function automatic logic [7:0] rd_byte(input logic idp, input logic [AW-1:0] a);
		logic [7:0] v;
		v = idp ? id_reg[a[PW-1:0]] : mem_reg[a];
		return v;
	endfunction

	// ----------------------------------------------------------------
	// link state machine (pclk domain)
	// ----------------------------------------------------------------
	sefe_pkg::sefe_state_t state_reg, state_next;
	logic [3:0]    cnt_reg, cnt_next;          // scl rises in this byte
	logic [1:0]    idx_reg, idx_next;          // which byte of the frame
	logic          rw_reg, rw_next;            // frame is a read
	logic          idp_reg, idp_next;          // frame targets the id page
	logic          ack_reg, ack_next;          // ack given / received
	logic          dat_reg, dat_next;          // last byte was a data byte
	logic          armed_reg, armed_next;      // stop now starts a write
	logic [AW-1:0] addr_reg, addr_next;        // internal address counter
	logic [7:0]    tx_reg, tx_next;            // byte being sent
	logic          oe_reg, oe_next;            // pulling sda low
	logic [NP-1:0] valid_reg, valid_next;      // buffered page entries
	logic [AW-PW-1:0] wpage_reg, wpage_next;   // page of the pending write
	logic          wid_reg, wid_next;          // pending write is the id page
	logic [31:0]   timer_reg, timer_next;      // programming countdown
	logic          standby_reg, sda_o_reg;

	// next-state for the protocol engine and the storage it writes
	always_comb begin
		logic [7:0] rx;
		logic       hit, blocked;
		rx         = link_shift_reg;  // stable since the eighth rise, long ago
		hit        = 1'b0;
		blocked    = 1'b0;
		state_next = state_reg;
		cnt_next   = cnt_reg;
		idx_next   = idx_reg;
		rw_next    = rw_reg;
		idp_next   = idp_reg;
		ack_next   = ack_reg;
		dat_next   = dat_reg;
		armed_next = armed_reg;
		addr_next  = addr_reg;
		tx_next    = tx_reg;
		oe_next    = oe_reg;
		valid_next = valid_reg;
		wpage_next = wpage_reg;
		wid_next   = wid_reg;
		timer_next = timer_reg;
		mem_next   = mem_reg;
		id_next    = id_reg;
		buf_next   = buf_reg;
		if (state_reg == sefe_pkg::ST_WRITE) begin
			// output off and every request ignored until done
			oe_next    = 1'b0;
			timer_next = timer_reg - 32'h1;
			if (timer_reg == 32'h0) begin
				// commit the page at the end of the cycle
				for (int i = 0; i < NP; i++) begin
					if (valid_reg[i] && wid_reg) begin
						id_next[i] = buf_reg[i];
					end else if (valid_reg[i]) begin
						mem_next[{wpage_reg, PW'(i)}] = buf_reg[i];
					end
				end
				valid_next = '0;
				state_next = sefe_pkg::ST_STANDBY;
			end
		end else if (bus_start) begin
			// outside a write cycle, start aborts anything and opens a new frame
			state_next = sefe_pkg::ST_RX;
			cnt_next   = 4'h0;
			idx_next   = sefe_pkg::IDX_SEL;
			oe_next    = 1'b0;
			armed_next = 1'b0;
			valid_next = '0;
		end else if (bus_stop) begin
			oe_next = 1'b0;
			if (armed_reg && (|valid_reg)) begin
				state_next = sefe_pkg::ST_WRITE;
				timer_next = WRITE_CYCLES - 32'h2;
			end else begin
				state_next = sefe_pkg::ST_STANDBY;
			end
			armed_next = 1'b0;
		end else begin
			case (state_reg)
				sefe_pkg::ST_RX: begin
					if (scl_rise) begin
						cnt_next   = cnt_reg + 4'h1;
						// the tenth-slot rise keeps it armed for a stop; any later rise disarms
						armed_next = armed_reg & (cnt_reg == 4'h0);
					end else if (scl_fall && cnt_reg == sefe_pkg::BYTE_BITS) begin
						dat_next = 1'b0;
						ack_next = 1'b1;
						case (idx_reg)
							sefe_pkg::IDX_SEL: begin
								// type field and straps must both agree
								hit = (rx[3:1] == strap_s) &&
								      ((rx[7:4] == sefe_pkg::TYPE_ARRAY) ||
								       (HAS_ID_PAGE && rx[7:4] == sefe_pkg::TYPE_IDPAGE));
								ack_next = hit;
								rw_next  = rx[0];
								idp_next = (rx[7:4] == sefe_pkg::TYPE_IDPAGE);
							end
							sefe_pkg::IDX_ADDR_HI: begin
								addr_next[AW-1:8] = rx[AW-9:0];  // acked even if protected
							end
							sefe_pkg::IDX_ADDR_LO: begin
								addr_next[7:0] = rx;
							end
							default: begin
								// data byte: protection turns it into a no-ack
								blocked  = idp_reg ? lock_reg : wp_s;
								ack_next = ~blocked;
								dat_next = 1'b1;
								if (!blocked) begin
									buf_next[addr_reg[PW-1:0]]   = rx;
									valid_next[addr_reg[PW-1:0]] = 1'b1;
									wpage_next = addr_reg[AW-1:PW];
									wid_next   = idp_reg;
									addr_next[PW-1:0] = addr_reg[PW-1:0] + PW'(1);
								end
							end
						endcase
						if (idx_reg == sefe_pkg::IDX_SEL && !hit) begin
							state_next = sefe_pkg::ST_STANDBY;  // deselect
						end else begin
							oe_next    = ~blocked;
							state_next = sefe_pkg::ST_ACK;
						end
						if (idx_reg != sefe_pkg::IDX_DATA) begin
							idx_next = idx_reg + 2'h1;
						end
					end
				end
				sefe_pkg::ST_ACK: begin
					if (scl_fall) begin
						cnt_next = 4'h0;
						if (rw_reg) begin
							// first read byte goes out right after the ack
							tx_next    = rd_byte(idp_reg, addr_reg);
							oe_next    = ~tx_next[7];
							addr_next  = idp_reg ? {addr_reg[AW-1:PW], addr_reg[PW-1:0] + PW'(1)}
							                     : addr_reg + AW'(1);
							state_next = sefe_pkg::ST_TX;
						end else begin
							oe_next    = 1'b0;
							armed_next = ack_reg & dat_reg;
							state_next = sefe_pkg::ST_RX;
						end
					end
				end
				sefe_pkg::ST_TX: begin
					if (scl_rise) begin
						cnt_next = cnt_reg + 4'h1;
					end else if (scl_fall) begin
						if (cnt_reg == sefe_pkg::BYTE_BITS) begin
							oe_next    = 1'b0;  // release for the master's ack
							state_next = sefe_pkg::ST_MACK;
						end else begin
							oe_next = ~tx_reg[3'h7 - cnt_reg[2:0]];
						end
					end
				end
				sefe_pkg::ST_MACK: begin
					if (scl_rise) begin
						ack_next = ~sda_s;
					end else if (scl_fall) begin
						cnt_next = 4'h0;
						if (ack_reg) begin
							tx_next    = rd_byte(idp_reg, addr_reg);
							oe_next    = ~tx_next[7];
							addr_next  = idp_reg ? {addr_reg[AW-1:PW], addr_reg[PW-1:0] + PW'(1)}
							                     : addr_reg + AW'(1);
							state_next = sefe_pkg::ST_TX;
						end else begin
							state_next = sefe_pkg::ST_STANDBY;  // no-ack ends the read
						end
					end
				end
				default: begin
					state_next = sefe_pkg::ST_STANDBY;
				end
			endcase
		end
	end

	// engine registers; reset is the power-on detector, so nothing answers
	// while it is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg   <= sefe_pkg::ST_STANDBY;
			cnt_reg     <= 4'h0;
			idx_reg     <= sefe_pkg::IDX_SEL;
			rw_reg      <= 1'b0;
			idp_reg     <= 1'b0;
			ack_reg     <= 1'b0;
			dat_reg     <= 1'b0;
			armed_reg   <= 1'b0;
			addr_reg    <= '0;
			tx_reg      <= 8'h00;
			oe_reg      <= 1'b0;
			valid_reg   <= '0;
			wpage_reg   <= '0;
			wid_reg     <= 1'b0;
			timer_reg   <= 32'h0;
			standby_reg <= 1'b1;
			sda_o_reg   <= 1'b0;
		end else begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			idx_reg     <= idx_next;
			rw_reg      <= rw_next;
			idp_reg     <= idp_next;
			ack_reg     <= ack_next;
			dat_reg     <= dat_next;
			armed_reg   <= armed_next;
			addr_reg    <= addr_next;
			tx_reg      <= tx_next;
			oe_reg      <= oe_next;
			valid_reg   <= valid_next;
			wpage_reg   <= wpage_next;
			wid_reg     <= wid_next;
			timer_reg   <= timer_next;
			standby_reg <= (state_next == sefe_pkg::ST_STANDBY);
			sda_o_reg   <= 1'b0;  // open drain: only ever low
		end
	end

	// storage has no reset; contents are non-volatile in spirit
	always_ff @(posedge pclk) begin
		mem_reg <= mem_next;
		id_reg  <= id_next;
		buf_reg <= buf_next;
	end

	// ----------------------------------------------------------------
	// apb slave: status, lock control, peek window into the array
	// ----------------------------------------------------------------
	logic        pready_reg, pready_next;
	logic        pslverr_reg, pslverr_next;
	logic [31:0] prdata_reg, prdata_next;
	logic [13:0] peek_reg, peek_next;

	// one wait state; writes land on the edge that sees pready high
	always_comb begin
		logic access, mapped;
		access       = psel & penable;
		mapped       = (paddr[31:12] == 20'h0) &&
		               (paddr[11:0] == sefe_pkg::OFF_STATUS ||
		                paddr[11:0] == sefe_pkg::OFF_CTRL ||
		                paddr[11:0] == sefe_pkg::OFF_PEEK_ADDR ||
		                paddr[11:0] == sefe_pkg::OFF_PEEK_DATA);
		pready_next  = access & ~pready_reg;
		pslverr_next = access & ~pready_reg & ~mapped;
		prdata_next  = 32'h0;
		lock_next    = lock_reg;
		peek_next    = peek_reg;
		if (access && !pready_reg && !pwrite && mapped) begin
			case (paddr[11:0])
				sefe_pkg::OFF_STATUS: begin
					prdata_next[sefe_pkg::STAT_STANDBY_BIT] = standby_reg;
					prdata_next[sefe_pkg::STAT_BUSY_BIT]    = (state_reg == sefe_pkg::ST_WRITE);
					prdata_next[sefe_pkg::STAT_WP_BIT]      = wp_s;
					prdata_next[sefe_pkg::STAT_LOCK_BIT]    = lock_reg;
				end
				sefe_pkg::OFF_CTRL: prdata_next[sefe_pkg::CTRL_LOCK_BIT] = lock_reg;
				sefe_pkg::OFF_PEEK_ADDR: prdata_next[13:0] = peek_reg;
				default: prdata_next[7:0] = mem_reg[peek_reg];
			endcase
		end
		if (access && pready_reg && pwrite && mapped) begin
			if (paddr[11:0] == sefe_pkg::OFF_CTRL) begin
				// lock can only be set, never cleared
				lock_next = lock_reg | pwdata[sefe_pkg::CTRL_LOCK_BIT];
			end else if (paddr[11:0] == sefe_pkg::OFF_PEEK_ADDR) begin
				peek_next = pwdata[13:0];
			end
		end
	end

	// bus answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0;
			lock_reg    <= sefe_pkg::LOCK_RST;
			peek_reg    <= sefe_pkg::PEEK_RST;
		end else begin
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg  <= prdata_next;
			lock_reg    <= lock_next;
			peek_reg    <= peek_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from flops
	// ----------------------------------------------------------------
	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;
	assign sda_o   = sda_o_reg;
	assign sda_oe  = oe_reg;
	assign standby = standby_reg;

endmodule

// ==== verif/sefe_asserts.sv ====
// checker: port-level properties of the serial eeprom front end
`timescale 1ns/1ps
module sefe_asserts #(
	parameter int unsigned WRITE_CYCLES = 50   // programming time in pclk
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        scl,
	input wire logic        sda_i,
	input wire logic        sda_o,
	input wire logic        sda_oe,
	input wire logic        standby
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic mapped;   // the four word registers at the bottom of the map
	assign mapped = (paddr[31:4] == 28'h0) && (paddr[1:0] == 2'h0);

	a_pin_low_only: assert property (sda_oe |-> !sda_o)
		else $error("data pin driven high");
	a_idle_release: assert property (standby |-> !sda_oe)
		else $error("data pin held in standby");
	a_reset_exit: assert property ($rose(presetn) |-> standby && !sda_oe && !pready)
		else $error("outputs not quiet after reset");
	// a change only after the clock has been low for a while, never near a rise
	a_pin_on_low: assert property ($changed(sda_oe) |-> !scl && !$past(scl, 2))
		else $error("data pin moved while clock high");
	a_start_wakes: assert property ($fell(sda_i) && scl && $past(scl) && standby
		|-> ##[1:6] !standby)
		else $error("start not seen");
	a_ready_answer: assert property (psel && penable && !pready |=> pready)
		else $error("bus answer late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("bus answer too long");
	a_err_unmapped: assert property (pready |-> pslverr == !mapped)
		else $error("bus error flag wrong");
	a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");

	c_ack: cover property ($rose(sda_oe));
	c_err: cover property (pready && pslverr);
	c_wake: cover property ($fell(standby));
endmodule

// ==== verif/sefe_link_master.sv ====
// model: two-wire bus master that drives the serial clock
`timescale 1ns/1ps
module sefe_link_master #(
	parameter int HALF_NS = 500   // half period, 1 MHz at most
) (
	output logic      scl,    // serial clock, high while idle
	output logic      m_oe,   // high while the master pulls data low
	input  wire logic sda     // resolved data line
);
	// idle bus: clock parked high, data released to the pull-up
	initial begin
		scl = 1'b1;
		m_oe = 1'b0;
	end

	// start or repeated start: data falls while the clock is high
	task automatic start_c();
		m_oe = 1'b0;
		#(HALF_NS / 2) scl = 1'b1;
		#(HALF_NS / 2) m_oe = 1'b1;
		#(HALF_NS) scl = 1'b0;
	endtask

	// stop: data rises while the clock is high, clock then stays parked
	task automatic stop_c();
		m_oe = 1'b1;
		#(HALF_NS / 2) scl = 1'b1;
		#(HALF_NS / 2) m_oe = 1'b0;
		#(HALF_NS);
	endtask

	// one clock: data changes only while the clock is low
	task automatic bit_c(input logic tx, output logic rx);
		m_oe = !tx;
		#(HALF_NS / 2) scl = 1'b1;
		#(HALF_NS / 2) rx = sda;
		#(HALF_NS / 2) scl = 1'b0;
		#(HALF_NS / 2);
	endtask

	// byte out, then release the line for the device's answer
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_c(d[i], r);
		end
		bit_c(1'b1, r);
		ack = !r;
	endtask

	// byte in, then our own answer on the ninth clock
	task automatic recv_byte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_c(1'b1, d[i]);
		end
		bit_c(!ack, r);
	endtask
endmodule

// ==== verif/tb_top.sv ====
// testbench: register bus and link traffic, acks, storage and protection
`timescale 1ns/1ps
module tb_top;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int unsigned WCYC = 500;   // shortened so a whole select fits inside
	logic        pclk, presetn, psel, penable, pwrite;
	logic [31:0] paddr, pwdata, prdata, seed, rd;
	logic        pready, pslverr, scl, m_oe, sda_o, sda_oe, standby, wp, ack, err;
	logic [2:0]  straps;
	logic [7:0]  dat, b, code;
	logic [13:0] adr;
	int          n_fail, checked, cyc, t0;
	wire         sda = !(sda_oe | m_oe);   // open drain with pull-up

	sefe_top #(.WRITE_CYCLES(WCYC), .HAS_ID_PAGE(1'b1)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .strap_select_bit2(straps[2]),
		.strap_select_bit1(straps[1]), .strap_select_bit0(straps[0]),
		.write_protect_input(wp), .standby(standby));
	sefe_link_master m (.scl(scl), .m_oe(m_oe), .sda(sda));

	always #12.5 pclk = ~pclk;

	// cycle count; a hang ends the run as a failure
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// the device answers only its own type and strap field
	function automatic logic sel_ack(input logic [7:0] c, input logic [2:0] st);
		return (c[7:4] == sefe_pkg::TYPE_ARRAY || c[7:4] == sefe_pkg::TYPE_IDPAGE) && c[3:1] == st;
	endfunction
	task automatic chk1(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one bus transfer; request held until ready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {20'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// whole write frame: select, two address bytes, one data byte, stop
	task automatic wr_frame(input logic [7:0] d, input logic dack);
		m.start_c();
		m.send_byte({4'ha, straps, 1'b0}, ack);
		chk1("sel ack", 1'b1, ack);
		m.send_byte({2'h0, adr[13:8]}, ack);
		chk1("hi ack", 1'b1, ack);
		m.send_byte(adr[7:0], ack);
		chk1("lo ack", 1'b1, ack);
		m.send_byte(d, ack);
		chk1("data ack", dack, ack);
		m.stop_c();
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		{pclk, presetn, psel, penable, pwrite, wp, straps} = '0;
		{paddr, pwdata, n_fail, checked, cyc} = '0;
		seed = 32'ha264;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, sefe_pkg::OFF_STATUS, 32'h0);
		chk32("status", 32'h1, rd);
		apb(1'b0, 12'h010, 32'h0);
		chk1("unmapped", 1'b1, err);
		$display("test registers done");
		// select codes: random straps, wrong types and wrong strap fields
		for (int k = 0; k < 10; k++) begin
			seed = lfsr(seed);
			straps <= (k == 0) ? 3'h0 : seed[2:0];
			code = {(k % 4 == 2) ? 4'hc : 4'ha + 4'(k % 2), (k % 3 == 1) ? seed[5:3] : straps, 1'b0};
			repeat (4) @(posedge pclk);
			code[3:1] = (k % 3 == 1) ? seed[5:3] : straps;
			m.start_c();
			m.send_byte(code, ack);
			chk1("select", sel_ack(code, straps), ack);
			m.stop_c();
			repeat (6) @(posedge pclk);
			chk1("standby", 1'b1, standby);
		end
		$display("test select done");
		adr = seed[21:8];
		dat = seed[29:22];
		wr_frame(dat, 1'b1);
		t0 = cyc;
		apb(1'b0, sefe_pkg::OFF_STATUS, 32'h0);
		chk32("busy", 32'h2, rd);
		m.start_c();
		m.send_byte({4'ha, straps, 1'b0}, ack);
		chk1("ignored", 1'b0, ack);
		m.stop_c();
		do apb(1'b0, sefe_pkg::OFF_STATUS, 32'h0); while (rd[1] === 1'b1 && cyc < 30000);
		// t0 is taken about 20 cycles after the stop; busy lasts WCYC - 1 cycles
		chk1("write time", 1'b1, cyc - t0 >= WCYC - 20 && cyc - t0 <= WCYC - 12);
		apb(1'b1, sefe_pkg::OFF_PEEK_ADDR, {18'h0, adr});
		apb(1'b0, sefe_pkg::OFF_PEEK_DATA, 32'h0);
		chk32("stored", {24'h0, dat}, rd);
		m.start_c();
		m.send_byte({4'ha, straps, 1'b0}, ack);
		m.send_byte({2'h0, adr[13:8]}, ack);
		m.send_byte(adr[7:0], ack);
		m.start_c();
		m.send_byte({4'ha, straps, 1'b1}, ack);
		m.recv_byte(1'b0, b);
		m.stop_c();
		chk32("link read", {24'h0, dat}, {24'h0, b});
		$display("test write done");
		wp <= 1'b1;
		repeat (4) @(posedge pclk);
		wr_frame(~dat, 1'b0);
		repeat (6) @(posedge pclk);
		apb(1'b0, sefe_pkg::OFF_STATUS, 32'h0);
		chk32("protected", 32'h5, rd);
		apb(1'b0, sefe_pkg::OFF_PEEK_DATA, 32'h0);
		chk32("unchanged", {24'h0, dat}, rd);
		// id page lock: set once, a later zero must not clear it
		apb(1'b1, sefe_pkg::OFF_CTRL, 32'h1);
		apb(1'b1, sefe_pkg::OFF_CTRL, 32'h0);
		apb(1'b0, sefe_pkg::OFF_CTRL, 32'h0);
		chk32("lock", 32'h1, rd);
		$display("test protect done");
		// a select during a second reset goes unanswered
		@(posedge pclk);
		presetn <= 1'b0;
		m.start_c();
		m.send_byte({4'ha, straps, 1'b0}, ack);
		chk1("in reset", 1'b0, ack);
		m.stop_c();
		@(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		chk1("reset standby", 1'b1, standby);
		$display("test reset done");
		report_and_stop();
	end
endmodule

bind sefe_top sefe_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .scl(scl), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe(sda_oe), .standby(standby));
